//--- design/quarter_sine.sv
// quarter-wave sine: magnitude = sin(90 deg * position / 256), 8 bit
// assumes a purely combinational use; piecewise-linear over nine knots
`timescale 1ns/1ps

module quarter_sine
    import stepper_indexer_pkg::*;
(
    // table position in, magnitude out
    input wire logic [7:0] position,
    output logic [7:0] magnitude
);
    logic [2:0] seg;
    logic [4:0] frac;
    logic [7:0] lo;
    logic [7:0] hi;
    logic [12:0] slope;

    // linear blend between neighbouring knots, end point pinned to full scale
    always_comb begin
        seg = position[7:5];
        frac = position[4:0];
        lo = SINE_KNOT[seg];
        hi = SINE_KNOT[4'(seg) + 4'h1]; // 4 bits so the last segment reaches knot 8
        slope = 13'({5'h00, hi - lo} * {8'h00, frac});
        if (position == 8'hff) begin
            magnitude = FULL_SCALE;
        end else begin
            magnitude = lo + slope[12:5];
        end
    end
endmodule

//--- design/step_jitter_filter.sv
// step-frequency jitter filter feeding stall detection only
// assumes stepEdge is a one-cycle pulse per active edge from the indexer
`timescale 1ns/1ps

module step_jitter_filter
    import stepper_indexer_pkg::*;
#(
    parameter int PERIOD_W = 24
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // settings and step events
    input wire logic stepEdge,
    input wire logic jitterFilterDisable,
    input wire logic [1:0] jitterToleranceCode,
    // clean step towards stall detection
    output logic cleanStep,
    output logic [PERIOD_W-1:0] filteredPeriod
);
    typedef struct packed {
        logic valid;
        logic pulse;
        logic [PERIOD_W-1:0] count;
        logic [PERIOD_W-1:0] period;
        logic [PERIOD_W-1:0] phase;
    } filt_state_t;

    filt_state_t state_ff;
    filt_state_t nxt_state;
    logic [PERIOD_W-1:0] measured;
    logic [PERIOD_W-1:0] diff;
    logic [6:0] pct;
    logic inTol;

    // tolerance band in percent of the held period
    always_comb begin
        case (jitterToleranceCode)
            2'h0: pct = TOL_PCT_1;
            2'h1: pct = TOL_PCT_2;
            2'h2: pct = TOL_PCT_4;
            default: pct = TOL_PCT_6;
        endcase
        measured = state_ff.count + 1'b1;
        diff = (measured > state_ff.period) ? measured - state_ff.period
                                            : state_ff.period - measured;
        inTol = ((PERIOD_W+7)'(diff) * (PERIOD_W+7)'(PCT_FULL))
            <= ((PERIOD_W+7)'(state_ff.period) * (PERIOD_W+7)'(pct));
    end

    // jitter inside the band keeps the old cadence; a real change resyncs
    always_comb begin
        nxt_state = state_ff;
        nxt_state.pulse = 1'b0;
        if (~&state_ff.count) begin
            nxt_state.count = state_ff.count + 1'b1;
        end
        if (state_ff.phase + 1'b1 >= state_ff.period) begin
            nxt_state.phase = '0;
            nxt_state.pulse = state_ff.valid & ~jitterFilterDisable;
        end else begin
            nxt_state.phase = state_ff.phase + 1'b1;
        end
        if (stepEdge) begin
            nxt_state.count = '0;
            if (jitterFilterDisable | ~state_ff.valid | ~inTol) begin
                nxt_state.period = measured;
                nxt_state.phase = '0;
                nxt_state.pulse = 1'b1;
                nxt_state.valid = 1'b1;
            end
        end
        if (jitterFilterDisable) begin
            nxt_state.pulse = stepEdge; // no filtering: edges pass straight through
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            state_ff <= '0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign cleanStep = state_ff.pulse;
    assign filteredPeriod = state_ff.period;
endmodule

//--- design/stepper_indexer_pkg.sv
// shared constants, enumerations and carrier structs of the stepper indexer
// assumes one 50 MHz clock and a synchronous active-high reset everywhere

package stepper_indexer_pkg;

    // ------------------------------------------------------------
    // clock
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 20;

    // ------------------------------------------------------------
    // electrical angle: 1024 steps per revolution, 256 per quadrant
    // ------------------------------------------------------------
    localparam int ANGLE_W = 10;
    localparam logic [9:0] HOME_ANGLE = 10'h080;
    localparam logic [9:0] FULL_STEP_OFFSET = 10'h080;

    // ------------------------------------------------------------
    // stepping mode codes
    // ------------------------------------------------------------
    localparam logic [3:0] MODE_FULL_100 = 4'h0;
    localparam logic [3:0] MODE_FULL_71 = 4'h1;
    localparam logic [3:0] MODE_HALF_NONCIRC = 4'h2;
    localparam logic [3:0] MODE_HALF = 4'h3;
    localparam logic [3:0] MODE_QUARTER = 4'h4;
    localparam logic [3:0] MODE_MICRO_256 = 4'ha;
    localparam logic [3:0] MODE_RESET = 4'h0;

    // ------------------------------------------------------------
    // current magnitudes and quarter-sine knots (nine points, 0 to 90 deg)
    // ------------------------------------------------------------
    localparam logic [7:0] FULL_SCALE = 8'hff;
    localparam logic [7:0] SINE_KNOT [0:8] = '{8'h00, 8'h32, 8'h62, 8'h8e, 8'hb4,
                                              8'hd4, 8'hec, 8'hfa, 8'hff};

    // ------------------------------------------------------------
    // jitter filter
    // ------------------------------------------------------------
    localparam logic [1:0] TOL_CODE_RESET = 2'h1;
    localparam logic [6:0] TOL_PCT_1 = 7'h01;
    localparam logic [6:0] TOL_PCT_2 = 7'h02;
    localparam logic [6:0] TOL_PCT_4 = 7'h04;
    localparam logic [6:0] TOL_PCT_6 = 7'h06;
    localparam logic [6:0] PCT_FULL = 7'h64;

    // ------------------------------------------------------------
    // indexer phase
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        IDX_HOME = 2'b01,
        IDX_AWAY = 2'b10
    } idx_phase_t;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic [3:0] stepMode;
        logic stepEdgeBoth;
        logic serialStepSource;
        logic serialDirSource;
        logic serialDir;
        logic jitterFilterDisable;
        logic [1:0] jitterToleranceCode;
    } stepper_cfg_t;

    typedef struct packed {
        logic [7:0] coilATablePosition;
        logic [7:0] coilBTablePosition;
        logic coilAPolarity;
        logic coilBPolarity;
        logic [7:0] coilAExpectedCurrent;
        logic homeStatusBit;
    } indexer_report_t;

    typedef struct packed {
        logic polarity;
        logic [7:0] magnitude;
    } coil_drive_t;

endpackage

//--- design/stepper_indexer_sequencer.sv
// microstepping indexer for a two-coil stepper driver
// assumes step and direction pins already synchronous to sys_clk, and
// serial register bits presented as plain ports by the serial front end
//
// Summary of operation
// - full-step 100% walks 45,135,225,315 degrees
// - non-circular half step: eight states, full magnitude
// - serial mode: rising, or both edges if selected
// - hardware mode: rising step edge only
// - each active edge moves one state
// - direction low walks tables in reverse
// - mode change lands on next valid state
// - reset homes indexer at 45 degrees, defaults
// - indexer reset bit homes, keeps other settings
// - jitter tolerance 1,2,4,6 percent or off
// - filter feeds stall detection, not the indexer
// - coil positions 0..255 with sign bits
// - coil A current is sine of position
// - sign bit one means positive current
// - quadrant ramps and signs per coil
// - open-drain home pin low at home
// - serial home status bit zero at home
// - home seen once per four full steps
// - serial step bit steps once, self-clears
// - coil A sine, coil B cosine of angle
`timescale 1ns/1ps

module stepper_indexer_sequencer
    import stepper_indexer_pkg::*;
#(
    parameter int PERIOD_W = 24
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // interface strap, 1 selects serial behaviour
    input wire logic interfaceSelect,
    // step and direction pins
    input wire logic stepPin,
    input wire logic dirPin,
    // serial settings and write strobes
    input wire stepper_indexer_pkg::stepper_cfg_t cfg,
    input wire logic stepBitWrite,
    input wire logic indexerResetWrite,
    // readback of indexer state
    output stepper_indexer_pkg::indexer_report_t report,
    output logic serialStepBit,
    // coil current demands
    output stepper_indexer_pkg::coil_drive_t coilAOutput,
    output stepper_indexer_pkg::coil_drive_t coilBOutput,
    // open-drain home pin
    output logic homePulseOutput,
    output logic homePulseOe,
    // towards stall detection
    output logic cleanStep,
    output logic [PERIOD_W-1:0] filteredPeriod
);
    // ------------------------------------------------------------
    // state of the module
    // ------------------------------------------------------------
    typedef struct packed {
        idx_phase_t phase;
        logic serialMode;
        logic stepPinDly;
        logic stepBit;
        logic [ANGLE_W-1:0] angle;
        indexer_report_t report;
        coil_drive_t coilA;
        coil_drive_t coilB;
        logic homeOe;
    } core_state_t;

    core_state_t state_ff;
    core_state_t nxt_state;

    // ------------------------------------------------------------
    // mode decoding
    // ------------------------------------------------------------

    // distance between valid states of a mode, in 1/1024 revolution
    function automatic logic [ANGLE_W-1:0] stepSize(input logic [3:0] mode);
        logic [ANGLE_W-1:0] size;
        size = 10'h001;
        case (mode)
            MODE_FULL_100: size = 10'h100;
            MODE_FULL_71: size = 10'h100;
            MODE_HALF_NONCIRC: size = 10'h080;
            MODE_HALF: size = 10'h080;
            default: begin
                // 1/4 upward: each code halves the step
                if (mode >= MODE_QUARTER && mode <= MODE_MICRO_256) begin
                    size = 10'h040 >> (mode - MODE_QUARTER);
                end else begin
                    size = 10'h001; // unused codes fall back to the finest table
                end
            end
        endcase
        return size;
    endfunction

    // full-step tables sit on the diagonals, all others start at 0 degrees
    function automatic logic [ANGLE_W-1:0] gridOffset(input logic [3:0] mode);
        logic [ANGLE_W-1:0] off;
        off = '0;
        if (mode == MODE_FULL_100 || mode == MODE_FULL_71) begin
            off = FULL_STEP_OFFSET;
        end
        return off;
    endfunction

    // square tables drive plus or minus full scale, or zero
    function automatic logic squareTable(input logic [3:0] mode);
        return (mode == MODE_FULL_100) || (mode == MODE_HALF_NONCIRC);
    endfunction

    // next valid state in the walking direction; an off-grid angle left
    // behind by a mode change snaps to the nearest grid point ahead
    function automatic logic [ANGLE_W-1:0] nextAngle(input logic [ANGLE_W-1:0] angle,
                                                     input logic [3:0] mode,
                                                     input logic fwd);
        logic [ANGLE_W-1:0] size;
        logic [ANGLE_W-1:0] off;
        logic [ANGLE_W-1:0] rel;
        logic [ANGLE_W-1:0] base;
        size = stepSize(mode);
        off = gridOffset(mode);
        rel = angle - off;
        base = rel & ~(size - 10'h001);
        if (fwd) begin
            nextAngle = base + size + off;
        end else if (base == rel) begin
            nextAngle = base - size + off;
        end else begin
            nextAngle = base + off;
        end
    endfunction

    // ------------------------------------------------------------
    // step and direction sources
    // ------------------------------------------------------------
    logic serialMode;
    logic stepRise;
    logic stepFall;
    logic activeEdge;
    logic dirForward;
    logic homeRequest;
    logic [ANGLE_W-1:0] targetAngle;

    assign serialMode = state_ff.serialMode;
    assign stepRise = stepPin & ~state_ff.stepPinDly;
    assign stepFall = ~stepPin & state_ff.stepPinDly;

    // pick the active edge; serial bits are ignored in hardware mode
    always_comb begin
        if (serialMode && cfg.serialStepSource) begin
            activeEdge = state_ff.stepBit;
        end else if (serialMode) begin
            activeEdge = stepRise | (cfg.stepEdgeBoth & stepFall);
        end else begin
            activeEdge = stepRise;
        end
        if (serialMode && cfg.serialDirSource) begin
            dirForward = cfg.serialDir;
        end else begin
            dirForward = dirPin;
        end
    end

    // software indexer reset outranks a step in the same cycle
    assign homeRequest = serialMode & indexerResetWrite;

    always_comb begin
        if (homeRequest) begin
            targetAngle = HOME_ANGLE;
        end else if (activeEdge) begin
            targetAngle = nextAngle(state_ff.angle, cfg.stepMode, dirForward);
        end else begin
            targetAngle = state_ff.angle;
        end
    end

    // ------------------------------------------------------------
    // table positions and signs of the target angle
    // ------------------------------------------------------------
    logic [1:0] quadrant;
    logic [7:0] offsetInQuad;
    logic [7:0] posA;
    logic [7:0] posB;
    logic signA;
    logic signB;
    logic [7:0] sineA;
    logic [7:0] sineB;

    // odd quadrants ramp coil A down and coil B up
    always_comb begin
        quadrant = targetAngle[9:8];
        offsetInQuad = targetAngle[7:0];
        posA = quadrant[0] ? ~offsetInQuad : offsetInQuad;
        posB = quadrant[0] ? offsetInQuad : ~offsetInQuad;
        signA = ~quadrant[1];
        signB = (quadrant == 2'h0) || (quadrant == 2'h3);
    end

    // coil A follows the sine of the angle, coil B its cosine
    quarter_sine sineOfA (
        .position(posA),
        .magnitude(sineA)
    );

    quarter_sine sineOfB (
        .position(posB),
        .magnitude(sineB)
    );

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        nxt_state = state_ff;
        nxt_state.stepPinDly = stepPin;
        // self-clearing step bit; a new write wins over the clear
        nxt_state.stepBit = stepBitWrite & serialMode;
        nxt_state.angle = targetAngle;

        // readback, latched together with the angle
        nxt_state.report.coilATablePosition = posA;
        nxt_state.report.coilBTablePosition = posB;
        nxt_state.report.coilAPolarity = signA;
        nxt_state.report.coilBPolarity = signB;
        nxt_state.report.coilAExpectedCurrent = sineA;

        // drive demand; square tables snap nonzero coils to full scale
        nxt_state.coilA.polarity = signA;
        nxt_state.coilB.polarity = signB;
        if (squareTable(cfg.stepMode)) begin
            nxt_state.coilA.magnitude = (sineA == 8'h00) ? 8'h00 : FULL_SCALE;
            nxt_state.coilB.magnitude = (sineB == 8'h00) ? 8'h00 : FULL_SCALE;
        end else begin
            nxt_state.coilA.magnitude = sineA;
            nxt_state.coilB.magnitude = sineB;
        end

        // home tracking: exact 45 degree state only, once per revolution
        case (state_ff.phase)
            IDX_HOME: begin
                if (targetAngle != HOME_ANGLE) begin
                    nxt_state.phase = IDX_AWAY;
                end
            end
            IDX_AWAY: begin
                if (targetAngle == HOME_ANGLE) begin
                    nxt_state.phase = IDX_HOME;
                end
            end
            default: nxt_state.phase = IDX_HOME;
        endcase
        nxt_state.homeOe = (targetAngle == HOME_ANGLE);
        // status bit reads 0 at home; hardware mode leaves it idle high
        nxt_state.report.homeStatusBit = ~(serialMode & (targetAngle == HOME_ANGLE));
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------

    // power-up, undervoltage exit and wake all arrive as reset: home and
    // defaults; the strap is caught while reset is held and then frozen
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            state_ff.phase <= IDX_HOME;
            state_ff.serialMode <= interfaceSelect;
            state_ff.stepPinDly <= 1'b0;
            state_ff.stepBit <= 1'b0;
            state_ff.angle <= HOME_ANGLE;
            state_ff.report.coilATablePosition <= HOME_ANGLE[7:0];
            state_ff.report.coilBTablePosition <= ~HOME_ANGLE[7:0];
            state_ff.report.coilAPolarity <= 1'b1;
            state_ff.report.coilBPolarity <= 1'b1;
            state_ff.report.coilAExpectedCurrent <= SINE_KNOT[4]; // about 71 percent
            state_ff.report.homeStatusBit <= ~interfaceSelect;
            state_ff.coilA <= '{polarity: 1'b1, magnitude: SINE_KNOT[4]};
            state_ff.coilB <= '{polarity: 1'b1, magnitude: SINE_KNOT[4]};
            state_ff.homeOe <= 1'b1;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // ------------------------------------------------------------
    // stall-detection step filter
    // ------------------------------------------------------------

    // sees the same active edges as the indexer but never steers it
    step_jitter_filter #(
        .PERIOD_W(PERIOD_W)
    ) stallStepFilter (
        .sys_clk(sys_clk),
        .reset(reset),
        .stepEdge(activeEdge & ~homeRequest),
        .jitterFilterDisable(cfg.jitterFilterDisable),
        .jitterToleranceCode(cfg.jitterToleranceCode),
        .cleanStep(cleanStep),
        .filteredPeriod(filteredPeriod)
    );

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------

    // open drain: only ever pulls low, released otherwise
    assign homePulseOutput = 1'b0;
    assign homePulseOe = state_ff.homeOe;
    assign report = state_ff.report;
    assign serialStepBit = state_ff.stepBit;
    assign coilAOutput = state_ff.coilA;
    assign coilBOutput = state_ff.coilB;
endmodule

//--- tb/step_controller_model.sv
// system controller model driving step and direction pins
// assumes toggle requests arrive as one-cycle pulses on sys_clk
`timescale 1ns/1ps

module step_controller_model (
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // requests from the bench
    input wire logic toggleReq,
    input wire logic dirReq,
    // pins towards the indexer
    output logic stepPin,
    output logic dirPin
);
    // direction moves with the step edge so both are sampled together
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            stepPin <= 1'b0;
            dirPin <= 1'b1;
        end else begin
            if (toggleReq) begin
                stepPin <= ~stepPin;
            end
            dirPin <= dirReq;
        end
    end
endmodule

//--- tb/stepper_indexer_props.sv
// assertions on the stepper indexer top-level ports
// assumes one clock domain and a synchronous active-high reset
`timescale 1ns/1ps

module stepper_indexer_props
    import stepper_indexer_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // inputs
    input wire logic interfaceSelect,
    input wire logic stepPin,
    input wire stepper_indexer_pkg::stepper_cfg_t cfg,
    input wire logic stepBitWrite,
    input wire logic indexerResetWrite,
    // outputs
    input wire stepper_indexer_pkg::indexer_report_t report,
    input wire logic serialStepBit,
    input wire stepper_indexer_pkg::coil_drive_t coilAOutput,
    input wire stepper_indexer_pkg::coil_drive_t coilBOutput,
    input wire logic homePulseOe
);
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    logic serialMode_ff;
    logic [17:0] posSign;
    // positions and signs together: any real step changes them
    assign posSign = {report.coilATablePosition, report.coilBTablePosition,
                      report.coilAPolarity, report.coilBPolarity};
    // strap copy, taken only under reset as the pin is static
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            serialMode_ff <= interfaceSelect;
        end
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);
    // ----------------------------------------
    // properties
    // ----------------------------------------
    a_reset_home: assert property ($fell(reset) |-> homePulseOe
        && report.coilATablePosition == 8'h80 && report.coilAExpectedCurrent == 8'hb4)
        else $error("indexer not home after reset");
    a_home_pin: assert property (homePulseOe == (posSign == {8'h80, 8'h7f, 2'b11}))
        else $error("home pin disagrees with position");
    a_home_status: assert property (serialMode_ff && homePulseOe |-> !report.homeStatusBit)
        else $error("home status bit set at home");
    a_rise_steps: assert property ($rose(stepPin) && !indexerResetWrite
        && !(serialMode_ff && cfg.serialStepSource) |=> $changed(posSign))
        else $error("rising step edge ignored");
    a_hw_fall_idle: assert property (!serialMode_ff && $fell(stepPin) |=> $stable(posSign))
        else $error("falling edge stepped in hardware mode");
    a_both_edges: assert property (serialMode_ff && cfg.stepEdgeBoth && !indexerResetWrite
        && !cfg.serialStepSource && $fell(stepPin) |=> $changed(posSign))
        else $error("falling edge ignored in both-edge mode");
    a_fall_ignored: assert property (serialMode_ff && !cfg.stepEdgeBoth && $fell(stepPin)
        && !indexerResetWrite && !serialStepBit |=> $stable(posSign))
        else $error("falling edge stepped in rising mode");
    a_step_bit: assert property (serialMode_ff && stepBitWrite ##1 !stepBitWrite
        |-> serialStepBit ##1 !serialStepBit)
        else $error("step bit not a single-cycle pulse");
    a_serial_moves: assert property (serialMode_ff && cfg.serialStepSource && serialStepBit
        && !indexerResetWrite |=> $changed(posSign))
        else $error("serial step bit did not step");
    a_idx_reset: assert property (serialMode_ff && indexerResetWrite |=> homePulseOe
        && !report.homeStatusBit && report.coilAExpectedCurrent == 8'hb4)
        else $error("indexer reset did not home");
    a_coil_sign: assert property (coilAOutput.polarity == report.coilAPolarity
        && coilBOutput.polarity == report.coilBPolarity)
        else $error("coil polarity differs from sign bit");
    c_home: cover property ($rose(homePulseOe));
    c_idx: cover property (serialMode_ff && indexerResetWrite);
    c_bit: cover property (serialStepBit);
endmodule

bind stepper_indexer_sequencer stepper_indexer_props i_stepper_indexer_props (
    .sys_clk(sys_clk), .reset(reset), .interfaceSelect(interfaceSelect), .stepPin(stepPin),
    .cfg(cfg), .stepBitWrite(stepBitWrite), .indexerResetWrite(indexerResetWrite),
    .report(report), .serialStepBit(serialStepBit), .coilAOutput(coilAOutput),
    .coilBOutput(coilBOutput), .homePulseOe(homePulseOe));

//--- tb/tb_top.sv
// self-checking bench for the stepper indexer sequencer
// assumes the controller model on the pins and serial bits driven here
`timescale 1ns/1ps

module tb_top;
    import stepper_indexer_pkg::*;
    logic sys_clk = 0, reset = 1, interfaceSelect = 1, stepBitWrite = 0;
    logic indexerResetWrite = 0, toggleReq = 0, dirReq = 1, stepPin, dirPin;
    logic serialStepBit, homePulseOutput, homePulseOe, cleanStep;
    logic [11:0] filteredPeriod;
    logic [9:0] a;
    stepper_cfg_t cfg = '0;
    indexer_report_t report;
    coil_drive_t coilAOutput, coilBOutput;
    int n_fail = 0, check_count = 0;
    always #10 sys_clk = ~sys_clk;
    step_controller_model i_step_controller_model (.sys_clk(sys_clk), .reset(reset),
        .toggleReq(toggleReq), .dirReq(dirReq), .stepPin(stepPin), .dirPin(dirPin));
    // short period counter keeps the filter cheap
    stepper_indexer_sequencer #(.PERIOD_W(12)) i_stepper_indexer_sequencer (
        .sys_clk(sys_clk), .reset(reset), .interfaceSelect(interfaceSelect),
        .stepPin(stepPin), .dirPin(dirPin), .cfg(cfg), .stepBitWrite(stepBitWrite),
        .indexerResetWrite(indexerResetWrite), .report(report),
        .serialStepBit(serialStepBit), .coilAOutput(coilAOutput), .coilBOutput(coilBOutput),
        .homePulseOutput(homePulseOutput), .homePulseOe(homePulseOe),
        .cleanStep(cleanStep), .filteredPeriod(filteredPeriod));
    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic test_done;
        $display("checks %0d fails %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input logic [17:0] got, input logic [17:0] exp);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    // one pin toggle; outputs settle two edges later
    task automatic edg(input logic d);
        @(posedge sys_clk);
        toggleReq <= 1'b1;
        dirReq <= d;
        @(posedge sys_clk);
        toggleReq <= 1'b0;
        cyc(2);
    endtask
    // expected report for angle a; current only at sine knots
    task automatic exp_at(input logic sq);
        logic [7:0] pa, pb;
        pa = a[8] ? ~a[7:0] : a[7:0];
        pb = a[8] ? a[7:0] : ~a[7:0];
        chk({pa, pb, !a[9], a[9] == a[8]}, {report.coilATablePosition,
            report.coilBTablePosition, report.coilAPolarity, report.coilBPolarity});
        if (pa[4:0] == 5'h00) chk(report.coilAExpectedCurrent, SINE_KNOT[pa[7:5]]);
        chk({homePulseOutput, homePulseOe}, {1'b0, a == HOME_ANGLE});
        if (sq) chk({coilAOutput.magnitude, coilBOutput.magnitude},
            {pa == 0 ? 8'h00 : FULL_SCALE, pb == 0 ? 8'h00 : FULL_SCALE});
    endtask
    // pulse write strobes, let them land
    task automatic pulse(input logic s, input logic r);
        @(posedge sys_clk);
        stepBitWrite <= s;
        indexerResetWrite <= r;
        @(posedge sys_clk);
        stepBitWrite <= 1'b0;
        indexerResetWrite <= 1'b0;
        cyc(2);
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    initial begin
        cyc(4);
        reset <= 1'b0;
        cyc(1);
        a = HOME_ANGLE;
        exp_at(1'b0);
        chk(report.homeStatusBit, 1'b0);
        for (int i = 0; i < 4; i++) begin
            edg(1'b1);
            a = a + 10'h100;
            exp_at(1'b1);
            edg(1'b1);
            exp_at(1'b1);
        end
        chk(filteredPeriod, 12'h008);
        cfg.stepMode <= MODE_HALF_NONCIRC;
        cfg.stepEdgeBoth <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            edg(1'b0);
            a = a - 10'h080;
            exp_at(1'b1);
        end
        cfg.stepMode <= MODE_MICRO_256;
        edg(1'b1);
        a = 10'h081;
        exp_at(1'b0);
        cfg.stepMode <= MODE_FULL_100;
        edg(1'b1);
        a = 10'h180;
        exp_at(1'b1);
        pulse(1'b0, 1'b1);
        a = HOME_ANGLE;
        exp_at(1'b1);
        edg(1'b1);
        a = 10'h180;
        exp_at(1'b1);
        cfg.serialStepSource <= 1'b1;
        cfg.serialDirSource <= 1'b1;
        cfg.serialDir <= 1'b0;
        edg(1'b1);
        exp_at(1'b1);
        pulse(1'b1, 1'b0);
        a = HOME_ANGLE;
        exp_at(1'b1);
        cfg.serialStepSource <= 1'b0;
        cfg.serialDirSource <= 1'b0;
        reset <= 1'b1;
        interfaceSelect <= 1'b0;
        cyc(4);
        reset <= 1'b0;
        cyc(1);
        exp_at(1'b0);
        chk(report.homeStatusBit, 1'b1);
        edg(1'b1);
        a = 10'h180;
        exp_at(1'b1);
        edg(1'b1);
        exp_at(1'b1);
        pulse(1'b1, 1'b1);
        exp_at(1'b1);
        test_done();
    end
    // hang guard
    initial begin
        cyc(5000);
        n_fail++;
        test_done();
    end
endmodule
